/* rtl/csrb_defs.svh */
`ifndef CSRB_DEFS_SVH
`define CSRB_DEFS_SVH

// ----------------------------------------
// special register addresses
// ----------------------------------------
`define CSRB_ADDR_IND0    8'h00
`define CSRB_ADDR_PTR0    8'h01
`define CSRB_ADDR_IND1    8'h02
`define CSRB_ADDR_PTR1    8'h03
`define CSRB_ADDR_BANK    8'h04
`define CSRB_ADDR_WORK    8'h05
`define CSRB_ADDR_PCL     8'h06
`define CSRB_ADDR_TLOW    8'h07
`define CSRB_ADDR_TBH     8'h08
`define CSRB_ADDR_FLAGS   8'h0a
`define CSRB_ADDR_THIGH   8'h0c
`define CSRB_SFR_LAST     8'h3f

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSRB_BANK_BIT     0
`define CSRB_FLAG_C       0
`define CSRB_FLAG_AC      1
`define CSRB_FLAG_Z       2
`define CSRB_FLAG_OV      3
`define CSRB_FLAG_SLEEP   4
`define CSRB_FLAG_DOG     5

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define CSRB_PC_W         11
`define CSRB_BANK_RST     1'h0
`define CSRB_BYTE_RST     8'h00
`define CSRB_FLAG_RST     1'h0

`endif

/* rtl/csrb_pkg.sv */
`include "csrb_defs.svh"
package csrb_pkg;

  typedef enum logic [1:0] {
    csrb_mode_direct,
    csrb_mode_ind0,
    csrb_mode_ind1
  } csrb_mode_e;

  typedef enum logic [2:0] {
    csrb_op_add,
    csrb_op_sub,
    csrb_op_and,
    csrb_op_or,
    csrb_op_xor,
    csrb_op_rlc,
    csrb_op_rrc,
    csrb_op_pass
  } csrb_alu_op_e;

  typedef struct packed {
    logic                  bank;
    logic [7:0]            ptr0;
    logic [7:0]            ptr1;
    logic [7:0]            work;
    logic [7:0]            tlow;
    logic [7:0]            thigh;
    logic [7:0]            tbh;
    logic                  fc;
    logic                  fac;
    logic                  fz;
    logic                  fov;
    logic                  dog;
    logic                  sleep;
    logic                  mem_req;
    logic                  mem_we;
    logic                  mem_bank;
    logic [7:0]            mem_addr;
    logic [7:0]            mem_wdata;
    logic                  rd_valid;
    logic [7:0]            rd_data;
    logic                  rd_pend1;
    logic                  rd_pend2;
    logic                  prog_req;
    logic [15:0]           prog_addr;
    logic                  tbl_busy;
    logic [7:0]            tbl_dest;
    logic                  pc_load;
    logic [`CSRB_PC_W-1:0] pc_target;
    logic                  dummy_cycle;
  } csrb_state_s;

endpackage

/* rtl/csrb_alu_if.sv */
`timescale 1ns/1ps
interface csrb_alu_if;
  csrb_pkg::csrb_alu_op_e op;
  logic [7:0]             a;
  logic [7:0]             b;
  logic                   cin;
  logic [7:0]             res;
  logic                   c;
  logic                   ac;
  logic                   ov;
  logic                   z;
  logic                   upd_c;
  logic                   upd_arith;
  logic                   upd_z;

  modport core (output op, a, b, cin,
                input  res, c, ac, ov, z, upd_c, upd_arith, upd_z);
  modport alu  (input  op, a, b, cin,
                output res, c, ac, ov, z, upd_c, upd_arith, upd_z);
endinterface

/* rtl/csrb_alu.sv */
`timescale 1ns/1ps
module csrb_alu (
  csrb_alu_if.alu p
);
  logic [8:0] sum;
  logic [4:0] nib;

  // ----------------------------------------
  // result and flag terms
  // ----------------------------------------
  always_comb
  begin
    sum         = 9'h000;
    nib         = 5'h00;
    p.res       = p.a;
    p.c         = 1'b0;
    p.ac        = 1'b0;
    p.ov        = 1'b0;
    p.upd_c     = 1'b0;
    p.upd_arith = 1'b0;
    p.upd_z     = 1'b1;
    case (p.op)
      csrb_pkg::csrb_op_add:
      begin
        sum         = {1'b0, p.a} + {1'b0, p.b};
        nib         = {1'b0, p.a[3:0]} + {1'b0, p.b[3:0]};
        p.upd_c     = 1'b1;
        p.upd_arith = 1'b1;
      end
      csrb_pkg::csrb_op_sub:
      begin
        sum         = {1'b0, p.a} + {1'b0, ~p.b} + 9'h001;
        nib         = {1'b0, p.a[3:0]} + {1'b0, ~p.b[3:0]} + 5'h01;
        p.upd_c     = 1'b1;
        p.upd_arith = 1'b1;
      end
      csrb_pkg::csrb_op_and: p.res = p.a & p.b;
      csrb_pkg::csrb_op_or:  p.res = p.a | p.b;
      csrb_pkg::csrb_op_xor: p.res = p.a ^ p.b;
      csrb_pkg::csrb_op_rlc:
      begin
        p.res   = {p.a[6:0], p.cin};
        p.c     = p.a[7];
        p.upd_c = 1'b1;
        p.upd_z = 1'b0;
      end
      csrb_pkg::csrb_op_rrc:
      begin
        p.res   = {p.cin, p.a[7:1]};
        p.c     = p.a[0];
        p.upd_c = 1'b1;
        p.upd_z = 1'b0;
      end
      default: p.upd_z = 1'b0;
    endcase
    if (p.upd_arith)
    begin
      p.res = sum[7:0];
      p.c   = sum[8];
      p.ac  = nib[4];
      p.ov  = (p.a[7] ^ p.b[7] ^ sum[7] ^ p.op[0]) ^ sum[8];
    end
    p.z = (p.res == 8'h00);
  end
endmodule

/* rtl/csrb_core.sv */
// How it works
// - bank select bit picks bank 0 or 1; upper bits read zero
// - direct addresses always land in bank 0
// - first indirect port always uses bank 0 with pointer zero
// - second indirect port uses pointer one in the selected bank
// - resets clear bank select, except watchdog reset while idle
// - special registers decode the same in both banks
// - alu results go to work register; no register-to-register move
// - pc low write loads low pc byte, adds a dummy cycle
// - table read: high byte to table register, low to destination
// - writes to the flag register never touch expiry or sleep bits
// - expiry bit set by timeout, cleared by power-up, kick, sleep
// - sleep bit set by sleep, cleared by power-up or kick
// - signed wrap bit from carry into versus out of msb
// - null bit set when result is zero
// - nibble carry bit from low nibble carry or no borrow
// - carry bit from carry-out, no borrow, or rotate
// - flag register is never saved automatically on call or interrupt
// - flag bits 0..3 read-write, 4..5 read-only, 6..7 read zero
`timescale 1ns/1ps
`include "csrb_defs.svh"
module csrb_core (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire csrb_pkg::csrb_mode_e   req_mode,
  input  wire logic [7:0]             req_addr,
  input  wire logic [7:0]             req_wdata,
  output logic                        rd_valid,
  output logic [7:0]                  rd_data,
  input  wire logic                   alu_valid,
  input  wire csrb_pkg::csrb_alu_op_e alu_op,
  input  wire logic [7:0]             alu_operand,
  input  wire logic                   kick_watchdog_instr,
  input  wire logic                   sleep_instr,
  input  wire logic                   wdt_timeout,
  input  wire logic                   sys_reset_pulse,
  input  wire logic                   reset_keeps_bank,
  input  wire logic                   tbl_read,
  input  wire logic [7:0]             tbl_dest,
  output logic                        prog_req,
  output logic [15:0]                 prog_addr,
  input  wire logic                   prog_valid,
  input  wire logic [15:0]            prog_word,
  input  wire logic [`CSRB_PC_W-1:0]  pc_now,
  output logic                        pc_load,
  output logic [`CSRB_PC_W-1:0]       pc_target,
  output logic                        dummy_cycle,
  output logic                        mem_req,
  output logic                        mem_we,
  output logic                        mem_bank,
  output logic [7:0]                  mem_addr,
  output logic [7:0]                  mem_wdata,
  input  wire logic [7:0]             mem_rdata,
  output logic                        bank_sel_bit,
  output logic [7:0]                  core_flags
);
  csrb_pkg::csrb_state_s st_reg;
  csrb_pkg::csrb_state_s st_next;
  csrb_pkg::csrb_mode_e  eff_mode;
  logic [7:0]            r_addr;
  logic                  r_bank;
  logic                  r_void;
  logic                  r_sfr;
  logic                  tbl_done;
  logic                  w_en;
  logic [7:0]            w_addr;
  logic                  w_bank;
  logic [7:0]            w_data;
  logic                  w_own;
  logic                  rd_own;
  logic [7:0]            rd_sfr;
  logic [7:0]            flags_view;

  csrb_alu_if alu_bus ();

  csrb_alu u_alu (
    .p (alu_bus.alu)
  );

  assign alu_bus.op  = alu_op;
  assign alu_bus.a   = alu_operand;
  assign alu_bus.b   = st_reg.work;
  assign alu_bus.cin = st_reg.fc;

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  always_comb
  begin
    eff_mode = req_mode;
    if (req_mode == csrb_pkg::csrb_mode_direct)
    begin
      if (req_addr == `CSRB_ADDR_IND0)
        eff_mode = csrb_pkg::csrb_mode_ind0;
      else if (req_addr == `CSRB_ADDR_IND1)
        eff_mode = csrb_pkg::csrb_mode_ind1;
    end
    case (eff_mode)
      csrb_pkg::csrb_mode_ind0:
      begin
        r_addr = st_reg.ptr0;
        r_bank = 1'b0;
      end
      csrb_pkg::csrb_mode_ind1:
      begin
        r_addr = st_reg.ptr1;
        r_bank = st_reg.bank;
      end
      default:
      begin
        r_addr = req_addr;
        r_bank = 1'b0;
      end
    endcase
    r_void = (eff_mode != csrb_pkg::csrb_mode_direct) &&
             ((r_addr == `CSRB_ADDR_IND0) || (r_addr == `CSRB_ADDR_IND1));
    r_sfr = (r_addr <= `CSRB_SFR_LAST);
    if (r_sfr)
      r_bank = 1'b0;
  end

  // ----------------------------------------
  // special register read view
  // ----------------------------------------
  assign flags_view = {2'h0, st_reg.dog, st_reg.sleep,
                       st_reg.fov, st_reg.fz, st_reg.fac, st_reg.fc};

  always_comb
  begin
    rd_own = 1'b1;
    case (r_addr)
      `CSRB_ADDR_PTR0:  rd_sfr = st_reg.ptr0;
      `CSRB_ADDR_PTR1:  rd_sfr = st_reg.ptr1;
      `CSRB_ADDR_BANK:  rd_sfr = {7'h00, st_reg.bank};
      `CSRB_ADDR_WORK:  rd_sfr = st_reg.work;
      `CSRB_ADDR_PCL:   rd_sfr = pc_now[7:0];
      `CSRB_ADDR_TLOW:  rd_sfr = st_reg.tlow;
      `CSRB_ADDR_THIGH: rd_sfr = st_reg.thigh;
      `CSRB_ADDR_TBH:   rd_sfr = st_reg.tbh;
      `CSRB_ADDR_FLAGS: rd_sfr = flags_view;
      default:
      begin
        rd_sfr = 8'h00;
        rd_own = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // write source select
  // ----------------------------------------
  always_comb
  begin
    tbl_done = prog_valid && st_reg.tbl_busy;
    if (tbl_done)
    begin
      w_en   = 1'b1;
      w_addr = st_reg.tbl_dest;
      w_bank = 1'b0;
      w_data = prog_word[7:0];
    end
    else
    begin
      w_en   = req_valid && req_write && !r_void;
      w_addr = r_addr;
      w_bank = r_bank;
      w_data = req_wdata;
    end
    case (w_addr)
      `CSRB_ADDR_PTR0, `CSRB_ADDR_PTR1, `CSRB_ADDR_BANK,
      `CSRB_ADDR_WORK, `CSRB_ADDR_PCL, `CSRB_ADDR_TLOW,
      `CSRB_ADDR_THIGH, `CSRB_ADDR_TBH, `CSRB_ADDR_FLAGS: w_own = 1'b1;
      default: w_own = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_next             = st_reg;
    st_next.rd_valid    = 1'b0;
    st_next.mem_req     = 1'b0;
    st_next.mem_we      = 1'b0;
    st_next.prog_req    = 1'b0;
    st_next.pc_load     = 1'b0;
    st_next.dummy_cycle = st_reg.pc_load;
    st_next.rd_pend1    = 1'b0;
    st_next.rd_pend2    = st_reg.rd_pend1;
    if (st_reg.rd_pend2)
    begin
      st_next.rd_valid = 1'b1;
      st_next.rd_data  = mem_rdata;
    end
    if (req_valid && !req_write)
    begin
      if (r_void)
      begin
        st_next.rd_valid = 1'b1;
        st_next.rd_data  = 8'h00;
      end
      else if (rd_own)
      begin
        st_next.rd_valid = 1'b1;
        st_next.rd_data  = rd_sfr;
      end
      else
      begin
        st_next.mem_req  = 1'b1;
        st_next.mem_bank = r_bank;
        st_next.mem_addr = r_addr;
        st_next.rd_pend1 = 1'b1;
      end
    end
    if (w_en && w_own)
    begin
      case (w_addr)
        `CSRB_ADDR_PTR0:  st_next.ptr0  = w_data;
        `CSRB_ADDR_PTR1:  st_next.ptr1  = w_data;
        `CSRB_ADDR_BANK:  st_next.bank  = w_data[`CSRB_BANK_BIT];
        `CSRB_ADDR_WORK:  st_next.work  = w_data;
        `CSRB_ADDR_TLOW:  st_next.tlow  = w_data;
        `CSRB_ADDR_THIGH: st_next.thigh = w_data;
        `CSRB_ADDR_PCL:
        begin
          st_next.pc_load   = 1'b1;
          st_next.pc_target = {pc_now[`CSRB_PC_W-1:8], w_data};
        end
        `CSRB_ADDR_FLAGS:
        begin
          st_next.fc  = w_data[`CSRB_FLAG_C];
          st_next.fac = w_data[`CSRB_FLAG_AC];
          st_next.fz  = w_data[`CSRB_FLAG_Z];
          st_next.fov = w_data[`CSRB_FLAG_OV];
        end
        default: st_next.tbh = st_reg.tbh;
      endcase
    end
    else if (w_en)
    begin
      st_next.mem_req   = 1'b1;
      st_next.mem_we    = 1'b1;
      st_next.mem_bank  = w_bank;
      st_next.mem_addr  = w_addr;
      st_next.mem_wdata = w_data;
    end
    if (alu_valid)
    begin
      st_next.work = alu_bus.res;
      if (alu_bus.upd_c)
        st_next.fc = alu_bus.c;
      if (alu_bus.upd_arith)
      begin
        st_next.fac = alu_bus.ac;
        st_next.fov = alu_bus.ov;
      end
      if (alu_bus.upd_z)
        st_next.fz = alu_bus.z;
    end
    if (tbl_done)
    begin
      st_next.tbh      = prog_word[15:8];
      st_next.tbl_busy = 1'b0;
    end
    else if (tbl_read && !st_reg.tbl_busy)
    begin
      st_next.prog_req  = 1'b1;
      st_next.prog_addr = {st_reg.thigh, st_reg.tlow};
      st_next.tbl_busy  = 1'b1;
      st_next.tbl_dest  = tbl_dest;
    end
    if (kick_watchdog_instr || sleep_instr)
      st_next.dog = 1'b0;
    if (wdt_timeout)
      st_next.dog = 1'b1;
    if (kick_watchdog_instr)
      st_next.sleep = 1'b0;
    if (sleep_instr)
      st_next.sleep = 1'b1;
    if (sys_reset_pulse && !reset_keeps_bank)
      st_next.bank = `CSRB_BANK_RST;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_reg       <= '0;
      st_reg.bank  <= `CSRB_BANK_RST;
      st_reg.dog   <= `CSRB_FLAG_RST;
      st_reg.sleep <= `CSRB_FLAG_RST;
      st_reg.ptr0  <= `CSRB_BYTE_RST;
      st_reg.ptr1  <= `CSRB_BYTE_RST;
    end
    else
      st_reg <= st_next;
  end

  assign rd_valid     = st_reg.rd_valid;
  assign rd_data      = st_reg.rd_data;
  assign prog_req     = st_reg.prog_req;
  assign prog_addr    = st_reg.prog_addr;
  assign pc_load      = st_reg.pc_load;
  assign pc_target    = st_reg.pc_target;
  assign dummy_cycle  = st_reg.dummy_cycle;
  assign mem_req      = st_reg.mem_req;
  assign mem_we       = st_reg.mem_we;
  assign mem_bank     = st_reg.mem_bank;
  assign mem_addr     = st_reg.mem_addr;
  assign mem_wdata    = st_reg.mem_wdata;
  assign bank_sel_bit = st_reg.bank;
  assign core_flags   = {2'h0, st_reg.dog, st_reg.sleep,
                         st_reg.fov, st_reg.fz, st_reg.fac, st_reg.fc};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_direct_bank0;
    @(posedge mclk) disable iff (reset)
    (req_valid && req_mode == csrb_pkg::csrb_mode_direct &&
     req_addr > `CSRB_SFR_LAST && !tbl_done)
    |=> (mem_req && !mem_bank && mem_addr == $past(req_addr));
  endproperty
  a_direct_bank0: assert property (p_direct_bank0)
    else $error("direct access left bank 0");

  property p_ind0_bank0;
    @(posedge mclk) disable iff (reset)
    (req_valid && req_mode == csrb_pkg::csrb_mode_ind0 &&
     st_reg.ptr0 > `CSRB_SFR_LAST)
    |=> (mem_req && !mem_bank && mem_addr == $past(st_reg.ptr0));
  endproperty
  a_ind0_bank0: assert property (p_ind0_bank0)
    else $error("first indirect port not in bank 0");

  property p_ind1_bank;
    @(posedge mclk) disable iff (reset)
    (req_valid && !req_write && req_mode == csrb_pkg::csrb_mode_ind1 &&
     st_reg.ptr1 > `CSRB_SFR_LAST)
    |=> (mem_req && mem_bank == $past(bank_sel_bit) &&
         mem_addr == $past(st_reg.ptr1));
  endproperty
  a_ind1_bank: assert property (p_ind1_bank)
    else $error("second indirect port used wrong bank");

  property p_bank_keep;
    @(posedge mclk) disable iff (reset)
    (sys_reset_pulse && reset_keeps_bank && !(w_en && w_own &&
     w_addr == `CSRB_ADDR_BANK)) |=> $stable(bank_sel_bit);
  endproperty
  a_bank_keep: assert property (p_bank_keep)
    else $error("idle watchdog reset changed bank");

  property p_pcl_jump;
    @(posedge mclk) disable iff (reset)
    (w_en && w_addr == `CSRB_ADDR_PCL)
    |=> (pc_load && pc_target[7:0] == $past(w_data) &&
         pc_target[`CSRB_PC_W-1:8] == $past(pc_now[`CSRB_PC_W-1:8]))
    ##1 (dummy_cycle && !pc_load);
  endproperty
  a_pcl_jump: assert property (p_pcl_jump)
    else $error("pc low write did not jump in page");

  property p_flag_protect;
    @(posedge mclk) disable iff (reset)
    (!kick_watchdog_instr && !sleep_instr && !wdt_timeout)
    |=> $stable(core_flags[5:4]);
  endproperty
  a_flag_protect: assert property (p_flag_protect)
    else $error("expiry or sleep bit changed without event");

  property p_dog_set;
    @(posedge mclk) disable iff (reset)
    wdt_timeout |=> core_flags[`CSRB_FLAG_DOG];
  endproperty
  a_dog_set: assert property (p_dog_set)
    else $error("timeout did not set expiry bit");

  property p_sleep_flags;
    @(posedge mclk) disable iff (reset)
    (sleep_instr && !wdt_timeout)
    |=> (core_flags[`CSRB_FLAG_SLEEP] && !core_flags[`CSRB_FLAG_DOG]);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep did not set sleep bit and clear expiry");

  property p_table_read;
    @(posedge mclk) disable iff (reset)
    tbl_done |=> (st_reg.tbh == $past(prog_word[15:8]) &&
                  !st_reg.tbl_busy);
  endproperty
  a_table_read: assert property (p_table_read)
    else $error("table high byte not captured");
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "csrb_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam csrb_pkg::csrb_mode_e md = csrb_pkg::csrb_mode_direct;
  localparam csrb_pkg::csrb_mode_e m0 = csrb_pkg::csrb_mode_ind0;
  localparam csrb_pkg::csrb_mode_e m1 = csrb_pkg::csrb_mode_ind1;
  logic mclk = 0, reset = 1, req_valid = 0, req_write = 0;
  csrb_pkg::csrb_mode_e req_mode = md;
  csrb_pkg::csrb_alu_op_e alu_op = csrb_pkg::csrb_op_add;
  logic [7:0] req_addr = 0, req_wdata = 0, alu_operand = 0, tbl_dest = 0;
  logic [7:0] mem_rdata = 8'h5a, rd_data, mem_addr, mem_wdata, core_flags;
  logic alu_valid = 0, kick = 0, sleep_instr = 0, wdt_timeout = 0;
  logic sys_reset_pulse = 0, reset_keeps_bank = 0, tbl_read = 0;
  logic prog_valid = 0, rd_valid, prog_req, pc_load, dummy_cycle;
  logic mem_req, mem_we, mem_bank, bank_sel_bit;
  logic [15:0] prog_word = 0, prog_addr;
  logic [10:0] pc_now = 0, pc_target;
  logic [31:0] r;
  logic [7:0] d, p, q, a, w, hi, lo;
  logic [3:0] f;
  logic [11:0] e;
  int fail_count = 0, checks = 0, cycles = 0;

  csrb_core dut (.mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_write(req_write), .req_mode(req_mode), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_operand(alu_operand),
    .kick_watchdog_instr(kick), .sleep_instr(sleep_instr),
    .wdt_timeout(wdt_timeout), .sys_reset_pulse(sys_reset_pulse),
    .reset_keeps_bank(reset_keeps_bank), .tbl_read(tbl_read),
    .tbl_dest(tbl_dest), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_valid(prog_valid), .prog_word(prog_word), .pc_now(pc_now),
    .pc_load(pc_load), .pc_target(pc_target), .dummy_cycle(dummy_cycle),
    .mem_req(mem_req), .mem_we(mem_we), .mem_bank(mem_bank),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .bank_sel_bit(bank_sel_bit), .core_flags(core_flags));

  always #25 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [11:0] alu_f(input logic [2:0] op,
    input logic [7:0] x, y, input logic [3:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic ov, ac, c;
    ov = fl[3];
    ac = fl[1];
    c = fl[0];
    s = {1'b0, x};
    case (op)
      3'd0:
      begin
        s = x + y;
        h = x[3:0] + y[3:0];
        c = s[8];
        ac = h[4];
        ov = (x[7] == y[7]) && (s[7] != x[7]);
      end
      3'd1:
      begin
        s = x - y;
        c = x >= y;
        ac = x[3:0] >= y[3:0];
        ov = (x[7] != y[7]) && (s[7] != x[7]);
      end
      3'd2: s[7:0] = x & y;
      3'd3: s[7:0] = x | y;
      3'd4: s[7:0] = x ^ y;
      3'd5:
      begin
        s[7:0] = {x[6:0], c};
        c = x[7];
      end
      3'd6:
      begin
        s[7:0] = {c, x[7:1]};
        c = x[0];
      end
      default: s[7:0] = x;
    endcase
    return {s[7:0], ov, (op < 3'd5) ? (s[7:0] == 8'h00) : fl[2], ac, c};
  endfunction

  task acc(input logic wr, input csrb_pkg::csrb_mode_e m,
    input logic [7:0] ad, dt);
    req_write = wr;
    req_mode = m;
    req_addr = ad;
    req_wdata = dt;
    req_valid = 1;
    @(posedge mclk);
    #1;
  endtask

  task rd(input csrb_pkg::csrb_mode_e m, input logic [7:0] ad,
    output logic [7:0] v);
    int i;
    acc(0, m, ad, 8'h00);
    for (i = 0; i < 6 && rd_valid !== 1'b1; i++)
    begin
      req_valid = 0;
      @(posedge mclk);
      #1;
    end
    v = rd_data;
  endtask

  task ev(input logic [2:0] m);
    req_valid = 0;
    {wdt_timeout, sleep_instr, kick} = m;
    @(posedge mclk);
    #1;
    {wdt_timeout, sleep_instr, kick} = 3'b000;
    @(posedge mclk);
    #1;
  endtask

  task end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk);
    #1;
    reset = 0;
    void'($urandom(2));
    `CHK(core_flags, 8'h00)
    `CHK(bank_sel_bit, 1'b0)
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      d = r[7:0];
      p = 8'h40 | (r[15:8] & 8'h3f);
      acc(1, md, `CSRB_ADDR_BANK, d);
      rd(md, `CSRB_ADDR_BANK, q);
      `CHK(q, {7'h00, d[0]})
      `CHK(bank_sel_bit, d[0])
      acc(1, md, `CSRB_ADDR_PTR0, p);
      acc(1, md, `CSRB_ADDR_PTR1, p);
      acc(1, k[0] ? md : m0, `CSRB_ADDR_IND0, d);
      `CHK({mem_req, mem_we, mem_bank, mem_addr}, {3'b110, p})
      `CHK(mem_wdata, d)
      acc(1, k[1] ? md : m1, `CSRB_ADDR_IND1, d);
      `CHK({mem_req, mem_bank, mem_addr}, {1'b1, d[0], p})
      acc(1, md, p, d);
      `CHK({mem_req, mem_bank, mem_addr}, {2'b10, p})
      mem_rdata = r[23:16];
      rd(m1, 8'h00, q);
      `CHK(q, r[23:16])
      acc(1, md, `CSRB_ADDR_WORK, p);
      acc(1, md, `CSRB_ADDR_PTR1, `CSRB_ADDR_WORK);
      rd(m1, 8'h00, q);
      `CHK(q, p)
    end
    acc(1, md, `CSRB_ADDR_BANK, 8'h01);
    req_valid = 0;
    sys_reset_pulse = 1;
    reset_keeps_bank = 1;
    @(posedge mclk);
    #1;
    sys_reset_pulse = 0;
    reset_keeps_bank = 0;
    @(posedge mclk);
    #1;
    `CHK(bank_sel_bit, 1'b1)
    sys_reset_pulse = 1;
    @(posedge mclk);
    #1;
    sys_reset_pulse = 0;
    @(posedge mclk);
    #1;
    `CHK(bank_sel_bit, 1'b0)
    acc(1, md, `CSRB_ADDR_FLAGS, 8'h00);
    f = 4'h0;
    for (int k = 0; k < 48; k++)
    begin
      r = $urandom;
      {a, w} = (k < 4) ? 16'(64'h8080_7f01_0000_0f01 >> (48 - 16 * k))
                       : r[15:0];
      alu_op = csrb_pkg::csrb_alu_op_e'(k[2:0]);
      if (k[2:0] == 3'd5 || k[2:0] == 3'd6)
        a = w;
      acc(1, md, `CSRB_ADDR_WORK, w);
      req_valid = 0;
      alu_operand = a;
      alu_valid = 1;
      @(posedge mclk);
      #1;
      alu_valid = 0;
      e = alu_f(k[2:0], a, w, f);
      f = e[3:0];
      `CHK(core_flags[3:0], f)
      rd(md, `CSRB_ADDR_WORK, q);
      `CHK(q, e[11:4])
    end
    acc(1, md, `CSRB_ADDR_FLAGS, 8'hff);
    `CHK(core_flags, 8'h0f)
    ev(3'b010);
    `CHK(core_flags, 8'h1f)
    ev(3'b100);
    `CHK(core_flags, 8'h3f)
    acc(1, md, `CSRB_ADDR_FLAGS, 8'h00);
    rd(md, `CSRB_ADDR_FLAGS, q);
    `CHK(q, 8'h30)
    ev(3'b010);
    `CHK(core_flags, 8'h10)
    ev(3'b001);
    `CHK(core_flags, 8'h00)
    for (int k = 0; k < 4; k++)
    begin
      r = $urandom;
      pc_now = r[10:0];
      acc(1, md, `CSRB_ADDR_PCL, r[23:16]);
      `CHK(pc_load, 1'b1)
      `CHK(pc_target, {r[10:8], r[23:16]})
      req_valid = 0;
      @(posedge mclk);
      #1;
      `CHK(dummy_cycle, 1'b1)
    end
    r = $urandom;
    {hi, lo} = r[15:0];
    acc(1, md, `CSRB_ADDR_TLOW, lo);
    acc(1, md, `CSRB_ADDR_THIGH, hi);
    req_valid = 0;
    tbl_dest = `CSRB_ADDR_WORK;
    tbl_read = 1;
    @(posedge mclk);
    #1;
    tbl_read = 0;
    `CHK({prog_req, prog_addr}, {1'b1, hi, lo})
    repeat (2) @(posedge mclk);
    #1;
    prog_word = r[31:16];
    prog_valid = 1;
    @(posedge mclk);
    #1;
    prog_valid = 0;
    @(posedge mclk);
    #1;
    rd(md, `CSRB_ADDR_TBH, q);
    `CHK(q, r[31:24])
    rd(md, `CSRB_ADDR_WORK, q);
    `CHK(q, r[23:16])
    acc(1, md, `CSRB_ADDR_BANK, 8'h01);
    ev(3'b110);
    reset = 1;
    @(posedge mclk);
    #1;
    reset = 0;
    `CHK(bank_sel_bit, 1'b0)
    `CHK(core_flags, 8'h00)
    end_sim();
  end
endmodule
